/* File: rtl/ssbc_top.sv */
// synchronous late-write sram command decode, burst, output and sleep control
//
// Operation
// - selected read command loads address, begins read
// - read with output off stays high impedance
// - selected write with lane enabled, not in recovery, begins write
// - write with no lane enabled is abort
// - burst step continues burst, ignoring selects
// - continue cycles use advanced counter address
// - any unselected chip select gives deselect
// - clock hold freezes address, state, pipelines
// - hold keeps read driving, write undriven
// - drivers off during writes automatically
// - output on acts without clock; sleep request is sampled on clock edges
// - outputs high impedance from power-up
// - two-bit counter wraps after four accesses
// - linear order adds count modulo four
// - interleaved order xors start with count
// - latency select low gives flow-through
// - sleep request low means normal operation
// - sleep two cycles after request, then recovery
// - asleep: deselected, inputs ignored, outputs undriven
// - pipelined read data one edge after flow-through
// - each lane enable writes its own byte
`timescale 1ns/100ps
module ssbc_top #(
	parameter int RECOVERY_CYCLES = ssbc_pkg::SLEEP_RECOVERY_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// synchronous command inputs
	input wire logic clock_hold,
	input wire logic burst_step,
	input wire logic write_n,
	input wire logic [ssbc_pkg::LANES-1:0] byte_lane_n,
	input wire logic chip_sel_1_n,
	input wire logic chip_sel_2,
	input wire logic chip_sel_3_n,
	input wire logic [ssbc_pkg::ADDR_W-1:0] addr,
	// mode and level inputs
	input wire logic output_on_n,
	input wire logic sleep_request,
	input wire logic latency_select_n,
	input wire logic burst_order_select_n,
	// data pins
	input wire logic [ssbc_pkg::DATA_W-1:0] dq_in,
	output logic [ssbc_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	// memory core read port
	output logic core_rd_en,
	output logic [ssbc_pkg::ADDR_W-1:0] core_rd_addr,
	input wire logic [ssbc_pkg::DATA_W-1:0] core_rdata,
	// memory core write port
	output logic core_wr_valid,
	input wire logic core_wr_ready,
	output ssbc_pkg::ssbc_wword_type core_wr_word,
	// status
	output logic write_ready,
	output logic sleeping,
	output logic recovering
);
	import ssbc_pkg::*;

	localparam int REC_W = $clog2(RECOVERY_CYCLES + 1);

	generate
		if (RECOVERY_CYCLES < 1) begin : g_bad_recovery
			$error("recovery count must be at least one cycle");
		end
	endgenerate

	// ************************************************************
	// sleep control
	// ************************************************************
	logic sleep_seen;
	logic [REC_W-1:0] rec_count;

	always_ff @(posedge clk) begin
		if (srst) begin
			sleep_seen <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			sleep_seen <= sleep_request;
			sleeping <= sleep_request && sleep_seen;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rec_count <= '0;
		end else if (sleeping && !sleep_request) begin
			rec_count <= REC_W'(RECOVERY_CYCLES);
		end else if (rec_count != '0) begin
			rec_count <= rec_count - REC_W'(1);
		end
	end

	assign recovering = (rec_count != '0);

	// ************************************************************
	// command decode
	// ************************************************************
	ssbc_burst_type burst;
	ssbc_burst_type next_burst;
	logic active;
	logic selected;
	logic no_lanes;
	logic do_read;
	logic do_write;
	logic load;
	logic advance;
	logic [ADDR_W-1:0] addr_hi;
	logic [ADDR_W-1:0] access_addr;
	logic [BURST_W-1:0] next_low;

	assign active = !clock_hold && !sleeping;
	assign selected = !chip_sel_1_n && chip_sel_2 && !chip_sel_3_n;
	assign no_lanes = (byte_lane_n == LANES_OFF);

	always_comb begin
		next_burst = burst;
		do_read = 1'b0;
		do_write = 1'b0;
		load = 1'b0;
		advance = 1'b0;
		if (!burst_step) begin
			load = 1'b1;
			if (!selected) begin
				next_burst = burst_desel;
			end else if (write_n) begin
				next_burst = burst_read;
				do_read = 1'b1;
			end else if (no_lanes || recovering) begin
				next_burst = burst_desel;
			end else begin
				next_burst = burst_write;
				do_write = 1'b1;
			end
		end else begin
			// continuation ignores write_n and the chip selects
			advance = (burst != burst_desel);
			case (burst)
				burst_read: begin
					do_read = 1'b1;
				end
				burst_write: begin
					do_write = !no_lanes && !recovering;
					if (recovering) begin
						next_burst = burst_desel;
					end
				end
				default: begin
					next_burst = burst_desel;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			burst <= burst_desel;
			addr_hi <= '0;
		end else if (active) begin
			burst <= next_burst;
			if (load) begin
				addr_hi <= addr;
			end
		end
	end

	ssbc_burst_counter u_counter (
		.clk(clk),
		.srst(srst),
		.load(active && load),
		.advance(active && advance),
		.order_interleaved(burst_order_select_n),
		.load_low(addr[BURST_LSB +: BURST_W]),
		.next_low(next_low)
	);

	assign access_addr = load ? addr : {addr_hi[ADDR_W-1:BURST_W], next_low};

	// a dummy read with output off touches nothing
	assign core_rd_en = active && do_read && !output_on_n;
	assign core_rd_addr = access_addr;

	// ************************************************************
	// read data path
	// ************************************************************
	logic pipelined;
	logic rd_stage1;
	logic rd_stage2;
	logic [DATA_W-1:0] rd_pipe;
	logic read_drive;

	assign pipelined = latency_select_n;

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_stage1 <= 1'b0;
			rd_stage2 <= 1'b0;
		end else if (active) begin
			rd_stage1 <= core_rd_en;
			rd_stage2 <= rd_stage1;
		end
	end

	always_ff @(posedge clk) begin
		if (active && rd_stage1) begin
			rd_pipe <= core_rdata;
		end
	end

	assign read_drive = pipelined ? rd_stage2 : rd_stage1;
	assign dq_out = pipelined ? rd_pipe : core_rdata;
	// output on and reset gate the drivers without waiting for an edge; sleep gates them only from the edge that sets sleeping
	assign dq_oe_n = !(read_drive && !output_on_n && !sleeping && !srst);

	// ************************************************************
	// write data path
	// ************************************************************
	ssbc_wslot_type wslot1;
	ssbc_wslot_type wslot2;
	ssbc_wword_type wword;
	logic capture;

	always_ff @(posedge clk) begin
		if (srst) begin
			wslot1 <= '0;
			wslot2 <= '0;
		end else if (active) begin
			wslot1 <= '{valid: do_write, addr: access_addr, lane_n: byte_lane_n};
			wslot2 <= wslot1;
		end
	end

	// data is taken one edge after the command in flow-through, two when pipelined
	assign capture = active && (pipelined ? wslot2.valid : wslot1.valid);
	assign wword = pipelined ? ssbc_wword_type'{addr: wslot2.addr, lane_n: wslot2.lane_n, data: dq_in}
		: ssbc_wword_type'{addr: wslot1.addr, lane_n: wslot1.lane_n, data: dq_in};

	ssbc_word_buffer #(
		.WIDTH($bits(ssbc_wword_type)),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.clk(clk),
		.srst(srst),
		.in_valid(capture),
		.in_ready(write_ready),
		.in_data(wword),
		.out_valid(core_wr_valid),
		.out_ready(core_wr_ready),
		.out_data(core_wr_word)
	);

	// ************************************************************
	// checks
	// ************************************************************
	read_begin_a: assert property (@(posedge clk) disable iff (srst)
		(active && !burst_step && selected && write_n && !output_on_n) |=> rd_stage1) else $error("read not begun");
	write_begin_a: assert property (@(posedge clk) disable iff (srst)
		(active && !burst_step && selected && !write_n && !no_lanes && !recovering) |=> wslot1.valid)
		else $error("write not begun");
	write_abort_a: assert property (@(posedge clk) disable iff (srst)
		(active && !write_n && no_lanes && !burst_step) |=> !wslot1.valid && burst == burst_desel)
		else $error("abort wrote");
	deselect_cycle_a: assert property (@(posedge clk) disable iff (srst)
		(active && !burst_step && !selected) |=> (burst == burst_desel) && !rd_stage1 && !wslot1.valid)
		else $error("deselect not taken");
	continue_addr_a: assert property (@(posedge clk) disable iff (srst)
		(burst_step && burst == burst_read) |-> core_rd_addr[ADDR_W-1:BURST_W] == addr_hi[ADDR_W-1:BURST_W])
		else $error("continue used external address");
	hold_freeze_a: assert property (@(posedge clk) disable iff (srst)
		clock_hold |=> $stable(burst) && $stable(rd_stage2) && $stable(wslot2)) else $error("hold moved state");
	write_undriven_a: assert property (@(posedge clk) disable iff (srst)
		(wslot1.valid || wslot2.valid) && !rd_stage1 && !rd_stage2 |-> dq_oe_n) else $error("drove during write");
	reset_hiz_a: assert property (@(posedge clk) srst |-> dq_oe_n) else $error("drove during reset");
	sleep_entry_a: assert property (@(posedge clk) disable iff (srst)
		(!sleep_request ##1 sleep_request [*2]) |=> sleeping ##0 dq_oe_n && !core_rd_en && !capture)
		else $error("sleep not entered on time");
	pipe_latency_a: assert property (@(posedge clk) disable iff (srst)
		(core_rd_en && pipelined ##1 active [*2]) |-> rd_stage2) else $error("pipelined read late");
	recovery_block_a: assert property (@(posedge clk) disable iff (srst)
		recovering |-> !do_write) else $error("write accepted during recovery");
	recovery_len_a: assert property (@(posedge clk) disable iff (srst)
		(sleeping && !sleep_request) |=> (rec_count == REC_W'(RECOVERY_CYCLES))) else $error("recovery count wrong");

	read_burst_c: cover property (@(posedge clk) disable iff (srst)
		(active && !burst_step && selected && write_n) ##1 (active && burst_step) [*3]);
	flow_write_c: cover property (@(posedge clk) disable iff (srst) capture && !pipelined);
	sleep_cycle_c: cover property (@(posedge clk) disable iff (srst) sleeping ##1 recovering);
	hold_read_c: cover property (@(posedge clk) disable iff (srst) clock_hold && !dq_oe_n);

endmodule

/* File: common/ssbc_pkg.sv */
// shared constants and types of the synchronous sram burst controller
package ssbc_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int BURST_W = 2;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int BURST_LSB = 0;
	localparam logic [LANES-1:0] LANES_OFF = 4'hf;
	localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLEEP_ENTRY_CYCLES = 2;
	// recovery time is a plain default, set it per part
	localparam int SLEEP_RECOVERY_NS = 20;
	localparam int SLEEP_RECOVERY_CYCLES = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WBUF_DEPTH = 2;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		burst_desel,
		burst_read,
		burst_write
	} ssbc_burst_type;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lane_n;
	} ssbc_wslot_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lane_n;
		logic [DATA_W-1:0] data;
	} ssbc_wword_type;

endpackage

/* File: rtl/ssbc_burst_counter.sv */
// two-bit burst address counter, linear or interleaved
`timescale 1ns/100ps
module ssbc_burst_counter (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic load,
	input wire logic advance,
	input wire logic order_interleaved,
	input wire logic [ssbc_pkg::BURST_W-1:0] load_low,
	// address
	output logic [ssbc_pkg::BURST_W-1:0] next_low
);
	import ssbc_pkg::*;

	logic [BURST_W-1:0] start;
	logic [BURST_W-1:0] count;
	logic [BURST_W-1:0] next_count;

	always_ff @(posedge clk) begin
		if (srst) begin
			start <= BURST_RESET;
			count <= BURST_RESET;
		end else if (load) begin
			start <= load_low;
			count <= BURST_RESET;
		end else if (advance) begin
			count <= next_count;
		end
	end

	assign next_count = count + BURST_STEP;
	// interleaved is start xor count, linear is start plus count modulo four
	assign next_low = order_interleaved ? (start ^ next_count) : (start + next_count);

	// ************************************************************
	// checks
	// ************************************************************
	property wrap_after_four;
		@(posedge clk) disable iff (srst)
		(load ##1 (advance && !load) [*4]) |=> (count == BURST_RESET);
	endproperty
	burst_wrap_a: assert property (wrap_after_four) else $error("burst counter did not wrap after four");

	// first interleaved step after a load is the loaded low bits with bit zero flipped
	interleave_order_a: assert property (@(posedge clk) disable iff (srst)
		(order_interleaved && load) ##1 (advance && !load) |-> (next_low == ($past(load_low) ^ BURST_STEP)))
		else $error("interleaved order wrong");

endmodule

/* File: rtl/ssbc_word_buffer.sv */
// small fifo of flip-flops with valid and ready on both sides
`timescale 1ns/100ps
module ssbc_word_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("buffer depth must be a power of two of at least two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr;
	logic [PTR_W-1:0] rptr;
	logic [CNT_W-1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != CNT_W'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= wptr + PTR_W'(1);
			end
			if (pop) begin
				rptr <= rptr + PTR_W'(1);
			end
			count <= count + CNT_W'(push) - CNT_W'(pop);
		end
	end

	no_overflow_a: assert property (@(posedge clk) disable iff (srst)
		(count == CNT_W'(DEPTH) && !pop) |=> (count == CNT_W'(DEPTH))) else $error("buffer count moved while full");

endmodule

/* File: test/ssbc_core_model.sv */
// memory core model that answers the controller's read and write ports
`timescale 1ns/100ps
module ssbc_core_model (
	// clock
	input wire logic clk,
	// read port
	input wire logic core_rd_en,
	input wire logic [ssbc_pkg::ADDR_W-1:0] core_rd_addr,
	output logic [ssbc_pkg::DATA_W-1:0] core_rdata,
	// write port
	input wire logic stall,
	input wire logic core_wr_valid,
	output logic core_wr_ready,
	input wire ssbc_pkg::ssbc_wword_type core_wr_word
);
	import ssbc_pkg::*;

	// sixteen words, each preset to its own address nibble repeated nine times across the word
	logic [DATA_W-1:0] mem [16];

	// a stalled core refuses words so that the buffer must hold them
	assign core_wr_ready = !stall;

	// one process presets and then serves the core, so each variable has one driver
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = {9{i[3:0]}};
		end
		forever begin
			@(posedge clk);
			if (core_rd_en) begin
				core_rdata <= mem[core_rd_addr[3:0]];
			end
			if (core_wr_valid && core_wr_ready) begin
				for (int l = 0; l < LANES; l++) begin
					if (!core_wr_word.lane_n[l]) begin
						mem[core_wr_word.addr[3:0]][l*LANE_W +: LANE_W] <= core_wr_word.data[l*LANE_W +: LANE_W];
					end
				end
			end
		end
	end
endmodule

/* File: test/sync_sram_burst_control_bench.sv */
// self-checking bench of the sram burst controller
`timescale 1ns/100ps
module sync_sram_burst_control_bench;
	import ssbc_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	localparam int REC = 2;
	localparam logic [DATA_W-1:0] D0 = 36'h123456789;
	localparam logic [DATA_W-1:0] D1 = 36'habcdef012;
	logic clk, srst, clock_hold, burst_step, write_n, chip_sel_1_n, chip_sel_2, chip_sel_3_n;
	logic output_on_n, sleep_request, latency_select_n, burst_order_select_n, stall;
	logic dq_oe_n, core_rd_en, core_wr_valid, core_wr_ready, write_ready, sleeping, recovering;
	logic [LANES-1:0] byte_lane_n;
	logic [ADDR_W-1:0] addr, core_rd_addr;
	logic [DATA_W-1:0] dq_in, dq_out, core_rdata;
	ssbc_wword_type core_wr_word;
	int bad_count, tests_run;
	// rows: flow-through, interleaved, then the two low address bits of each of the four beats
	logic [9:0] rows [5] = '{10'h06c, 10'h14e, 10'h3b1, 10'h2c6, 10'h1e4};
	logic [2:0] dsel [3] = '{3'h3, 3'h0, 3'h6};

	ssbc_top #(.RECOVERY_CYCLES(REC)) u_ssbc_top (.clk(clk), .srst(srst), .clock_hold(clock_hold),
		.burst_step(burst_step), .write_n(write_n), .byte_lane_n(byte_lane_n), .chip_sel_1_n(chip_sel_1_n),
		.chip_sel_2(chip_sel_2), .chip_sel_3_n(chip_sel_3_n), .addr(addr), .output_on_n(output_on_n),
		.sleep_request(sleep_request), .latency_select_n(latency_select_n),
		.burst_order_select_n(burst_order_select_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.core_rd_en(core_rd_en), .core_rd_addr(core_rd_addr), .core_rdata(core_rdata),
		.core_wr_valid(core_wr_valid), .core_wr_ready(core_wr_ready), .core_wr_word(core_wr_word),
		.write_ready(write_ready), .sleeping(sleeping), .recovering(recovering));

	ssbc_core_model u_ssbc_core_model (.clk(clk), .core_rd_en(core_rd_en), .core_rd_addr(core_rd_addr),
		.core_rdata(core_rdata), .stall(stall), .core_wr_valid(core_wr_valid), .core_wr_ready(core_wr_ready),
		.core_wr_word(core_wr_word));

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one command cycle; returns with outputs settled inside that cycle
	task automatic cmd(input logic step, input logic wn, input logic [3:0] lanes, input logic [2:0] sel,
		input logic [ADDR_W-1:0] a, input logic hold);
		@(posedge clk);
		#1;
		clock_hold = hold;
		burst_step = step;
		write_n = wn;
		byte_lane_n = lanes;
		{chip_sel_3_n, chip_sel_2, chip_sel_1_n} = sel;
		addr = a;
		#1;
	endtask

	task automatic idle();
		cmd(1'b0, 1'b1, 4'hf, 3'h3, 20'h0, 1'b0);
	endtask

	function automatic logic [DATA_W-1:0] pat(input logic [3:0] a);
		return {9{a}};
	endfunction

	function automatic logic [1:0] sq(input logic [9:0] row, input int k);
		return row[7 - 2 * (k % 4) -: 2];
	endfunction

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
		input logic [LANES-1:0] lane_n);
		merge = old;
		for (int l = 0; l < LANES; l++) begin
			if (!lane_n[l]) begin
				merge[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
			end
		end
	endfunction

	// two-beat write burst into a stalled core, then drain
	task automatic wtest(input logic ft);
		int lat;
		lat = ft ? 1 : 2;
		latency_select_n = !ft;
		stall = 1'b1;
		for (int c = 0; c < 4; c++) begin
			if (c == 0) begin
				cmd(1'b0, 1'b0, 4'ha, 3'h2, 20'h00009, 1'b0);
			end else if (c == 1) begin
				cmd(1'b1, 1'b0, 4'h5, 3'h5, 20'h0, 1'b0);
			end else begin
				idle();
			end
			dq_in = (c == lat) ? D0 : (c == lat + 1) ? D1 : ~dq_in;
			chk("dq_oe_n", dq_oe_n, 1'b1);
		end
		idle();
		chk("write_ready", write_ready, 1'b0);
		chk("core_wr_valid", core_wr_valid, 1'b1);
		stall = 1'b0;
		#1;
		chk("wr_word", core_wr_word, {20'h00009, 4'ha, D0});
		idle();
		chk("wr_word", core_wr_word, {20'h0000a, 4'h5, D1});
		idle();
		chk("drained", {core_wr_valid, write_ready}, 2'h1);
		chk("mem9", u_ssbc_core_model.mem[9], merge(pat(4'h9), D0, 4'ha));
		chk("mem10", u_ssbc_core_model.mem[10], merge(pat(4'ha), D1, 4'h5));
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#200000;
		bad_count++;
		summarize();
	end

	initial begin
		int lat;
		{srst, clock_hold, burst_step, write_n, chip_sel_2, chip_sel_3_n, chip_sel_1_n} = 7'h41;
		{output_on_n, sleep_request, latency_select_n, burst_order_select_n, stall} = 5'h2;
		byte_lane_n = 4'hf;
		addr = 20'h0;
		dq_in = 36'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		#1;
		srst = 1'b0;
		foreach (rows[r]) begin
			idle();
			latency_select_n = !rows[r][9];
			burst_order_select_n = rows[r][8];
			lat = rows[r][9] ? 1 : 2;
			for (int b = 0; b < 7; b++) begin
				if (b < 5) begin
					cmd(b != 0, 1'b1, 4'hf, (b == 0) ? 3'h2 : 3'h5,
						(b == 0) ? {18'h1, sq(rows[r], 0)} : 20'h0000c, 1'b0);
					chk("core_rd_en", core_rd_en, 1'b1);
					chk("core_rd_addr", core_rd_addr, {18'h1, sq(rows[r], b)});
				end else begin
					idle();
				end
				if (b >= lat && b - lat < 5) begin
					chk("dq_oe_n", dq_oe_n, 1'b0);
					chk("dq_out", dq_out, pat({2'h1, sq(rows[r], b - lat)}));
				end
			end
		end
		latency_select_n = 1'b1;
		burst_order_select_n = 1'b0;
		// reset in the middle of a read burst; a continue after it must find no burst
		cmd(1'b0, 1'b1, 4'hf, 3'h2, 20'h00003, 1'b0);
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b0);
		srst = 1'b1;
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b0);
		chk("dq_oe_n", dq_oe_n, 1'b1);
		srst = 1'b0;
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b0);
		chk("rst_burst", {core_rd_en, dq_oe_n}, 2'h1);
		idle();
		chk("status", {sleeping, recovering, core_wr_valid, write_ready}, 4'h1);
		// dummy read, then a real one cut off by output on
		output_on_n = 1'b1;
		cmd(1'b0, 1'b1, 4'hf, 3'h2, 20'h00004, 1'b0);
		chk("core_rd_en", core_rd_en, 1'b0);
		idle();
		// output on returns after the dummy read was sampled: nothing may be driven
		output_on_n = 1'b0;
		idle();
		chk("dq_oe_n", dq_oe_n, 1'b1);
		cmd(1'b0, 1'b1, 4'hf, 3'h2, 20'h00004, 1'b0);
		idle();
		idle();
		chk("dq_out", {dq_oe_n, dq_out}, {1'b0, pat(4'h4)});
		output_on_n = 1'b1;
		#0.5;
		chk("dq_oe_n", dq_oe_n, 1'b1);
		output_on_n = 1'b0;
		// clock hold in the middle of a read burst
		cmd(1'b0, 1'b1, 4'hf, 3'h2, 20'h00004, 1'b0);
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b0);
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b1);
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b1);
		chk("dq_out", {dq_oe_n, dq_out}, {1'b0, pat(4'h4)});
		cmd(1'b1, 1'b1, 4'hf, 3'h5, 20'h0, 1'b0);
		chk("dq_out", {dq_oe_n, dq_out}, {1'b0, pat(4'h4)});
		chk("core_rd_addr", core_rd_addr, 20'h00006);
		idle();
		idle();
		// each chip select alone deselects, and a continue stays deselected
		foreach (dsel[i]) begin
			cmd(1'b0, 1'b1, 4'hf, dsel[i], 20'h00004, 1'b0);
			chk("core_rd_en", core_rd_en, 1'b0);
			cmd(1'b1, 1'b1, 4'hf, 3'h2, 20'h0, 1'b0);
			chk("core_rd_en", core_rd_en, 1'b0);
			idle();
			idle();
			chk("dq_oe_n", dq_oe_n, 1'b1);
		end
		wtest(1'b0);
		wtest(1'b1);
		latency_select_n = 1'b1;
		// write abort, then a continue with lanes on
		cmd(1'b0, 1'b0, 4'hf, 3'h2, 20'h00009, 1'b0);
		cmd(1'b1, 1'b0, 4'h0, 3'h5, 20'h0, 1'b0);
		dq_in = D1;
		repeat (3) begin
			idle();
			chk("wr_dq", {core_wr_valid, dq_oe_n}, 2'h1);
		end
		chk("mem9", u_ssbc_core_model.mem[9], merge(pat(4'h9), D0, 4'ha));
		// sleep entry, sleep, recovery
		sleep_request = 1'b1;
		idle();
		chk("sleeping", sleeping, 1'b0);
		idle();
		chk("sleeping", sleeping, 1'b1);
		cmd(1'b0, 1'b1, 4'hf, 3'h2, 20'h00004, 1'b0);
		chk("core_rd_en", core_rd_en, 1'b0);
		idle();
		chk("dq_oe_n", dq_oe_n, 1'b1);
		sleep_request = 1'b0;
		cmd(1'b0, 1'b0, 4'h0, 3'h2, 20'h00001, 1'b0);
		chk("sleep_rec", {sleeping, recovering}, 2'h1);
		cmd(1'b0, 1'b1, 4'hf, 3'h2, 20'h00004, 1'b0);
		chk("rec_read", {recovering, core_rd_en}, 2'h3);
		idle();
		chk("recovering", recovering, 1'b0);
		repeat (3) begin
			dq_in = ~dq_in;
			idle();
			chk("core_wr_valid", core_wr_valid, 1'b0);
		end
		summarize();
	end
endmodule
